// ===== dmct_byte_ctr.sv
// one 8-bit counter slice with load, clear on match and advance
`timescale 1ns/1ns
`default_nettype none
`include "dmct_cfg.svh"

module dmct_byte_ctr
  import dmct_pkg::*;
(
  input  wire logic       mclk,    // system clock
  input  wire logic       rst_b,   // synchronous reset, active low
  input  wire logic       tick,    // count enable pulse
  input  wire logic       clrHit,  // clear on compare match
  input  wire logic       load,    // software write
  input  wire logic [7:0] loadVal, // written value
  output logic      [7:0] count,   // counter value
  output logic            atMax    // counter holds all ones
);

  logic [7:0] next_count;

  // load beats clear, clear beats advance
  assign next_count = load   ? loadVal :
                      clrHit ? `DMCT_RST_CNT :
                      tick   ? count + 8'h01 : count;
  assign atMax      = (count == `DMCT_BYTE_MAX);

  // counter register
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      count <= `DMCT_RST_CNT;
    else
      count <= next_count;
  end

endmodule // dmct_byte_ctr
`default_nettype wire

// ===== dmct_cfg.svh
// register offsets, field positions and reset values of the dual-mode compare timer
`ifndef DMCT_CFG_SVH
`define DMCT_CFG_SVH

`define DMCT_ADDR_W        3
`define DMCT_OFS_CTRL      3'h0
`define DMCT_OFS_FLAGS     3'h1
`define DMCT_OFS_CNT_HI    3'h2
`define DMCT_OFS_CNT_LO    3'h3
`define DMCT_OFS_CMP_HI    3'h4
`define DMCT_OFS_CMP_LO    3'h5
`define DMCT_OFS_IRQ_REQ   3'h6
`define DMCT_OFS_IRQ_ALLOW 3'h7

`define DMCT_CTRL_WIDTH    7
`define DMCT_CTRL_URATE_HI 6
`define DMCT_CTRL_URATE_LO 5
`define DMCT_CTRL_ULEVEL   4
`define DMCT_CTRL_LRATE_HI 2
`define DMCT_CTRL_LRATE_LO 1
`define DMCT_CTRL_LLEVEL   0

`define DMCT_FLG_UWRAP     7
`define DMCT_FLG_UMATCH    6
`define DMCT_FLG_UWRAPIE   5
`define DMCT_FLG_UCLREN    4
`define DMCT_FLG_LWRAP     3
`define DMCT_FLG_LMATCH    2
`define DMCT_FLG_LWRAPIE   1
`define DMCT_FLG_LCLREN    0

`define DMCT_IRQ_UPPER     1
`define DMCT_IRQ_LOWER     0

`define DMCT_RST_CNT       8'h00
`define DMCT_RST_CMP       8'hFF
`define DMCT_RST_REG       8'h00
`define DMCT_BYTE_MAX      8'hFF

`define DMCT_PRE_W         5
`define DMCT_PRE_DIV32     5'h1F
`define DMCT_PRE_DIV16     4'hF
`define DMCT_PRE_DIV4      2'h3
`define DMCT_WDIV4_LAST    2'h3
`define DMCT_EV_HOLD_W     2'h2

`endif

// ===== dmct_cpu_model.sv
// processor-side register master for the dual-mode compare timer
`timescale 1ns/1ns
`default_nettype none
`include "dmct_cfg.svh"

module dmct_cpu_model
(
  input  wire logic                    mclk,     // system clock
  input  wire logic [7:0]              regRdata, // read data
  output logic      [`DMCT_ADDR_W-1:0] regAddr,  // register offset
  output logic      [7:0]              regWdata, // write data
  output logic                         regWr,    // write strobe
  output logic                         regRd     // read strobe
);
  // idle bus from time zero
  initial
  begin
    regAddr  = '0;
    regWdata = 8'h00;
    regWr    = 1'b0;
    regRd    = 1'b0;
  end

  // one write cycle, effect visible on return
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    #1;
  endtask

  // one read cycle, data taken in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask

  // flag clear: read first, then zero the bits outside keep
  task automatic clr_flags(input logic [7:0] keep);
    logic [7:0] d;
    rd(`DMCT_OFS_FLAGS, d);
    wr(`DMCT_OFS_FLAGS, d & keep);
  endtask
endmodule // dmct_cpu_model

`default_nettype wire

// ===== dmct_pkg.sv
// types of the dual-mode compare timer
package dmct_pkg;

  // power state of the chip, one-hot
  typedef enum logic [6:0] {
    DMCT_PS_ACTIVE    = 7'h01,
    DMCT_PS_SLEEP     = 7'h02,
    DMCT_PS_WATCH     = 7'h04,
    DMCT_PS_SUBACTIVE = 7'h08,
    DMCT_PS_SUBSLEEP  = 7'h10,
    DMCT_PS_STANDBY   = 7'h20,
    DMCT_PS_MODSTBY   = 7'h40
  } dmct_power_t;

  // count clock choice of one byte counter
  typedef enum logic [1:0] {
    DMCT_RATE_DIV32 = 2'h0,
    DMCT_RATE_DIV16 = 2'h1,
    DMCT_RATE_DIV4  = 2'h2,
    DMCT_RATE_WDIV4 = 2'h3
  } dmct_rate_t;

endpackage

// ===== dmct_timer.sv
// dual-mode compare timer: 16-bit or two 8-bit counters with flags and toggle pins
//
// Contract
// - Overflow flag sets when the 16-bit counter wraps from all ones to zero.
// - Match pulse fires as the counter leaves the matching value; flag sets then.
// - Reset initialises registers; standby halts counting; low-power states keep contents.
// - Watch-derived count clock passes a synchroniser; one system clock error allowed.
// - In watch-class states only the watch-derived source advances the counter.
// - In 16-bit mode upper pin toggles only on a full sixteen-bit match.
// - Control write with a match pulse drives pins to the written levels.
// - Compare write in the match cycle discards that match pulse.
// - Match pulses only come with a counter clock, never while it stops.
// - 16-bit: upper match on full match; lower match on lower byte match.
// - 16-bit: upper wrap on full wrap; lower wrap on low byte wrap.
// - Counter byte write in the overflow cycle suppresses the overflow pulse.
// - 8-bit mode: each byte counter toggles its own pin on its match.
// - Watch source: interrupt source one watch cycle, event pulses two.
// - Active: request flag re-sets if cleared while interrupt source holds.
// - Active: flag clears ignored while their event pulse still holds.
// - Subactive: request and status flags clear at any time.
// - Active with watch source: counter writes ignored; reads may be off by one.
// - Subactive: counter reads and writes work even with watch source.
// - Width select zero gives one 16-bit counter; one gives two 8-bit.
// - A status flag clears on a zero write after being read as one.
// - Match with clear enable resets the matching counter to zero.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "dmct_cfg.svh"

module dmct_timer
  import dmct_pkg::*;
(
  input  wire logic                    mclk,           // system clock, 50 MHz
  input  wire logic                    rst_b,          // synchronous reset, active low
  input  wire logic                    watchClkPin,    // asynchronous watch clock
  input  wire dmct_power_t             powerState,     // chip power state
  input  wire logic [`DMCT_ADDR_W-1:0] regAddr,        // register offset
  input  wire logic [7:0]              regWdata,       // write data
  input  wire logic                    regWr,          // write strobe
  input  wire logic                    regRd,          // read strobe
  output logic      [7:0]              regRdata,       // read data, cycle after strobe
  output logic                         upperTogglePin, // upper compare output
  output logic                         lowerTogglePin, // lower compare output
  output logic                         upperIrq,       // upper interrupt request
  output logic                         lowerIrq        // lower interrupt request
);

  // register state
  logic [7:0] timerControlReg;
  logic [3:0] flagCtrlBits;      // wrap enables and clear enables
  logic [1:0] wrapFlag;          // index 1 upper, 0 lower
  logic [1:0] matchFlag;
  logic [1:0] wrapArmed;
  logic [1:0] matchArmed;
  logic [1:0] irqRequest;
  logic [1:0] irqAllow;
  logic [7:0] compareByte [2];
  logic [7:0] countByte   [2];

  // watch pin synchroniser and divider
  logic                  wSync1;
  logic                  wSync2;
  logic                  wSync3;
  logic [1:0]            wDiv;
  logic [`DMCT_PRE_W-1:0] preCnt;

  // decoded controls
  logic       wideMode;
  dmct_rate_t rateSel [2];
  logic       inActive;
  logic       runSys;
  logic       runWatch;
  logic       wEdge;
  logic       wTick4;
  logic       tick32;
  logic       tick16;
  logic       tick4;

  // per-half event wiring
  logic [1:0] srcWatch;
  logic [1:0] rawTick;
  logic [1:0] cntTick;
  logic [1:0] byteEq;
  logic [1:0] atMax;
  logic [1:0] cntWr;
  logic [1:0] cmpWr;
  logic [1:0] matchP;
  logic [1:0] wrapP;
  logic [1:0] clrHit;
  logic [1:0] irqSrc;
  logic [1:0] srcHold;
  logic [1:0] evHoldCnt [2];
  logic [1:0] wrapIe;
  logic [1:0] clrEn;
  logic [1:0] levelBit;
  logic [1:0] pinState;

  // bus decode
  logic wrCtrl;
  logic wrFlags;
  logic wrReq;
  logic wrAllow;
  logic rdFlags;
  logic [7:0] flagsView;
  logic [7:0] next_rdata;

  assign wrCtrl  = regWr && (regAddr == `DMCT_OFS_CTRL);
  assign wrFlags = regWr && (regAddr == `DMCT_OFS_FLAGS);
  assign wrReq   = regWr && (regAddr == `DMCT_OFS_IRQ_REQ);
  assign wrAllow = regWr && (regAddr == `DMCT_OFS_IRQ_ALLOW);
  assign rdFlags = regRd && (regAddr == `DMCT_OFS_FLAGS);
  assign cmpWr   = {regWr && (regAddr == `DMCT_OFS_CMP_HI),
                    regWr && (regAddr == `DMCT_OFS_CMP_LO)};

  // control fields
  assign wideMode   = ~timerControlReg[`DMCT_CTRL_WIDTH];
  assign rateSel[1] = dmct_rate_t'(timerControlReg[`DMCT_CTRL_URATE_HI:`DMCT_CTRL_URATE_LO]);
  assign rateSel[0] = dmct_rate_t'(timerControlReg[`DMCT_CTRL_LRATE_HI:`DMCT_CTRL_LRATE_LO]);
  assign levelBit   = {timerControlReg[`DMCT_CTRL_ULEVEL], timerControlReg[`DMCT_CTRL_LLEVEL]};
  assign wrapIe     = {flagCtrlBits[3], flagCtrlBits[1]};
  assign clrEn      = {flagCtrlBits[2], flagCtrlBits[0]};

  // power state qualifiers
  assign inActive = (powerState == DMCT_PS_ACTIVE);
  assign runSys   = inActive || (powerState == DMCT_PS_SLEEP);
  assign runWatch = runSys || (powerState == DMCT_PS_WATCH) ||
                    (powerState == DMCT_PS_SUBACTIVE) || (powerState == DMCT_PS_SUBSLEEP);

  // watch clock pin synchroniser, first stage feeds only the second
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      wSync1 <= 1'b0;
      wSync2 <= 1'b0;
      wSync3 <= 1'b0;
    end
    else
    begin
      wSync1 <= watchClkPin;
      wSync2 <= wSync1;
      wSync3 <= wSync2;
    end
  end

  // watch edge and divide-by-four enable
  assign wEdge  = wSync2 & ~wSync3;
  assign wTick4 = wEdge && (wDiv == `DMCT_WDIV4_LAST);

  // watch divider and system prescaler
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      wDiv   <= 2'h0;
      preCnt <= '0;
    end
    else
    begin
      if (wEdge)
        wDiv <= wDiv + 2'h1;
      preCnt <= preCnt + 5'h01;
    end
  end

  assign tick32 = (preCnt == `DMCT_PRE_DIV32);
  assign tick16 = (preCnt[3:0] == `DMCT_PRE_DIV16);
  assign tick4  = (preCnt[1:0] == `DMCT_PRE_DIV4);

  // per-half count enables and event pulses
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_half
      logic [1:0] effRate;
      logic       sysTick;

      // in wide mode both halves follow the lower rate
      assign effRate      = (wideMode && gi == 1) ? rateSel[0] : rateSel[gi];
      assign srcWatch[gi] = (effRate == DMCT_RATE_WDIV4);
      assign sysTick      = (effRate == DMCT_RATE_DIV32) ? tick32 :
                            (effRate == DMCT_RATE_DIV16) ? tick16 : tick4;
      // standby halts, watch-class states need the watch source
      assign rawTick[gi]  = srcWatch[gi] ? (wTick4 && runWatch)
                                         : (sysTick && runSys);
      assign byteEq[gi]   = (countByte[gi] == compareByte[gi]);
      // counter writes locked out in active with watch source
      assign cntWr[gi]    = regWr && !(inActive && srcWatch[gi]) &&
                            (regAddr == ((gi == 1) ? `DMCT_OFS_CNT_HI : `DMCT_OFS_CNT_LO));
      assign irqSrc[gi]   = matchP[gi] | (wrapP[gi] & wrapIe[gi]);

      dmct_byte_ctr u_ctr (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .tick    (cntTick[gi]),
        .clrHit  (clrHit[gi]),
        .load    (cntWr[gi]),
        .loadVal (regWdata),
        .count   (countByte[gi]),
        .atMax   (atMax[gi])
      );

      // watch-source pulse widths for flag clear blocking
      always_ff @(posedge mclk)
      begin
        if (!rst_b)
        begin
          evHoldCnt[gi] <= 2'h0;
          srcHold[gi]   <= 1'b0;
        end
        else if ((matchP[gi] | wrapP[gi]) && srcWatch[gi])
        begin
          evHoldCnt[gi] <= `DMCT_EV_HOLD_W;
          srcHold[gi]   <= irqSrc[gi];
        end
        else if (wEdge)
        begin
          if (evHoldCnt[gi] != 2'h0)
            evHoldCnt[gi] <= evHoldCnt[gi] - 2'h1;
          srcHold[gi] <= 1'b0;
        end
      end

      // sticky flags, set wins over clear
      always_ff @(posedge mclk)
      begin
        if (!rst_b)
        begin
          wrapFlag[gi]   <= 1'b0;
          matchFlag[gi]  <= 1'b0;
          wrapArmed[gi]  <= 1'b0;
          matchArmed[gi] <= 1'b0;
          irqRequest[gi] <= 1'b0;
        end
        else
        begin
          if (wrapP[gi])
            wrapFlag[gi] <= 1'b1;
          else if (wrFlags && !regWdata[gi ? `DMCT_FLG_UWRAP : `DMCT_FLG_LWRAP] &&
                   wrapArmed[gi] && !(inActive && evHoldCnt[gi] != 2'h0))
            wrapFlag[gi] <= 1'b0;
          if (matchP[gi])
            matchFlag[gi] <= 1'b1;
          else if (wrFlags && !regWdata[gi ? `DMCT_FLG_UMATCH : `DMCT_FLG_LMATCH] &&
                   matchArmed[gi] && !(inActive && evHoldCnt[gi] != 2'h0))
            matchFlag[gi] <= 1'b0;
          // arm on a read showing one, disarm after any flag write
          if (rdFlags)
          begin
            wrapArmed[gi]  <= wrapFlag[gi];
            matchArmed[gi] <= matchFlag[gi];
          end
          else if (wrFlags)
          begin
            wrapArmed[gi]  <= 1'b0;
            matchArmed[gi] <= 1'b0;
          end
          // held source re-sets the request in active only
          if (irqSrc[gi] || (srcHold[gi] && inActive))
            irqRequest[gi] <= 1'b1;
          else if (wrReq && !regWdata[gi])
            irqRequest[gi] <= 1'b0;
        end
      end

      // toggle pin: control write loads level, match toggles
      always_ff @(posedge mclk)
      begin
        if (!rst_b)
          pinState[gi] <= 1'b0;
        else if (wrCtrl)
          pinState[gi] <= regWdata[gi ? `DMCT_CTRL_ULEVEL : `DMCT_CTRL_LLEVEL];
        else if (matchP[gi])
          pinState[gi] <= ~pinState[gi];
      end
    end
  endgenerate

  // counter chaining: upper advances on lower carry in wide mode
  assign cntTick[0] = rawTick[0];
  assign cntTick[1] = wideMode ? (rawTick[0] & atMax[0]) : rawTick[1];

  // match pulses, only with a count clock, dropped on compare write
  assign matchP[0] = rawTick[0] & byteEq[0] & ~cmpWr[0];
  assign matchP[1] = wideMode ? (rawTick[0] & (&byteEq) & ~(|cmpWr))
                              : (rawTick[1] & byteEq[1] & ~cmpWr[1]);

  // wrap pulses, suppressed by a coincident counter write
  assign wrapP[0] = rawTick[0] & atMax[0] & ~cntWr[0];
  assign wrapP[1] = wideMode ? (rawTick[0] & (&atMax) & ~(|cntWr))
                             : (rawTick[1] & atMax[1] & ~cntWr[1]);

  // clear on match: whole word by upper enable in wide mode
  assign clrHit[1] = matchP[1] & clrEn[1];
  assign clrHit[0] = wideMode ? (matchP[1] & clrEn[1]) : (matchP[0] & clrEn[0]);

  // upper pin toggles on full match only in wide mode
  assign upperTogglePin = pinState[1];
  assign lowerTogglePin = pinState[0];
  assign upperIrq       = irqRequest[1] & irqAllow[1];
  assign lowerIrq       = irqRequest[0] & irqAllow[0];

  // plain software registers
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      timerControlReg <= `DMCT_RST_REG;
      flagCtrlBits    <= 4'h0;
      irqAllow        <= 2'h0;
      compareByte[0]  <= `DMCT_RST_CMP;
      compareByte[1]  <= `DMCT_RST_CMP;
    end
    else
    begin
      if (wrCtrl)
        timerControlReg <= regWdata;
      if (wrFlags)
        flagCtrlBits <= {regWdata[`DMCT_FLG_UWRAPIE], regWdata[`DMCT_FLG_UCLREN],
                         regWdata[`DMCT_FLG_LWRAPIE], regWdata[`DMCT_FLG_LCLREN]};
      if (wrAllow)
        irqAllow <= regWdata[1:0];
      if (cmpWr[1])
        compareByte[1] <= regWdata;
      if (cmpWr[0])
        compareByte[0] <= regWdata;
    end
  end

  // read mux
  assign flagsView = {wrapFlag[1], matchFlag[1], flagCtrlBits[3:2],
                      wrapFlag[0], matchFlag[0], flagCtrlBits[1:0]};
  always_comb
  begin
    unique case (regAddr)
      `DMCT_OFS_CTRL:      next_rdata = timerControlReg;
      `DMCT_OFS_FLAGS:     next_rdata = flagsView;
      `DMCT_OFS_CNT_HI:    next_rdata = countByte[1];
      `DMCT_OFS_CNT_LO:    next_rdata = countByte[0];
      `DMCT_OFS_CMP_HI:    next_rdata = compareByte[1];
      `DMCT_OFS_CMP_LO:    next_rdata = compareByte[0];
      `DMCT_OFS_IRQ_REQ:   next_rdata = {6'h00, irqRequest};
      `DMCT_OFS_IRQ_ALLOW: next_rdata = {6'h00, irqAllow};
    endcase
  end

  // read data register, valid the cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      regRdata <= 8'h00;
    else if (regRd)
      regRdata <= next_rdata;
  end

endmodule // dmct_timer
`default_nettype wire

// ===== dmct_timer_sva.sv
// concurrent checks on the ports of the dual-mode compare timer
`timescale 1ns/1ns
`default_nettype none
`include "dmct_cfg.svh"

module dmct_timer_sva
  import dmct_pkg::*;
(
  input wire logic                    mclk,           // system clock
  input wire logic                    rst_b,          // synchronous reset
  input wire logic                    watchClkPin,    // watch clock
  input wire dmct_power_t             powerState,     // power state
  input wire logic [`DMCT_ADDR_W-1:0] regAddr,        // register offset
  input wire logic [7:0]              regWdata,       // write data
  input wire logic                    regWr,          // write strobe
  input wire logic                    regRd,          // read strobe
  input wire logic [7:0]              regRdata,       // read data
  input wire logic                    upperTogglePin, // upper compare output
  input wire logic                    lowerTogglePin, // lower compare output
  input wire logic                    upperIrq,       // upper request
  input wire logic                    lowerIrq        // lower request
);
  logic [7:0] ctrlSh;  // control register as last written
  logic [7:0] cmpHiSh; // upper compare byte as last written

  // write decodes and power-state classes
  wire logic ctrlWr   = regWr && regAddr == `DMCT_OFS_CTRL;
  wire logic cmpHiWr  = regWr && regAddr == `DMCT_OFS_CMP_HI;
  wire logic haltSt   = powerState == DMCT_PS_STANDBY || powerState == DMCT_PS_MODSTBY;
  wire logic subSt    = powerState == DMCT_PS_WATCH || powerState == DMCT_PS_SUBACTIVE
                        || powerState == DMCT_PS_SUBSLEEP;
  wire logic noWatch  = ctrlSh[2:1] != 2'h3 && (!ctrlSh[7] || ctrlSh[6:5] != 2'h3);
  wire logic cntLoWr  = regWr && regAddr == `DMCT_OFS_CNT_LO;
  wire logic cntLoRd  = regRd && regAddr == `DMCT_OFS_CNT_LO;

  // shadow copies taken from observed writes
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      ctrlSh  <= `DMCT_RST_REG;
      cmpHiSh <= `DMCT_RST_CMP;
    end
    else
    begin
      if (ctrlWr)
        ctrlSh <= regWdata;
      if (cmpHiWr)
        cmpHiSh <= regWdata;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_reset_outputs: assert property ($rose(rst_b) |->
    !upperTogglePin && !lowerTogglePin && !upperIrq && !lowerIrq)
    else $error("outputs not cleared by reset");
  a_reset_rdata: assert property ($rose(rst_b) |-> regRdata == 8'h00)
    else $error("read data not cleared by reset");
  a_ctrl_level: assert property (ctrlWr |=> upperTogglePin ==
    $past(regWdata[`DMCT_CTRL_ULEVEL]) && lowerTogglePin == $past(regWdata[`DMCT_CTRL_LLEVEL]))
    else $error("pins not loaded from control write");
  a_standby_hold: assert property (haltSt && !ctrlWr |=>
    $stable(upperTogglePin) && $stable(lowerTogglePin))
    else $error("pin moved while halted");
  a_sub_src_halt: assert property (subSt && noWatch && !ctrlWr |=>
    $stable(upperTogglePin) && $stable(lowerTogglePin))
    else $error("pin moved without watch source");
  a_ctrl_readback: assert property (regRd && regAddr == `DMCT_OFS_CTRL |=>
    regRdata == ctrlSh)
    else $error("control read mismatch");
  a_cmp_readback: assert property (regRd && regAddr == `DMCT_OFS_CMP_HI |=>
    regRdata == cmpHiSh)
    else $error("compare read mismatch");
  a_sub_cnt_exact: assert property (powerState == DMCT_PS_SUBACTIVE && cntLoWr
    ##2 cntLoRd |=> regRdata == $past(regWdata, 3)
    || regRdata == $past(regWdata, 3) + 8'h01 || regRdata == 8'h00)
    else $error("counter write lost in subactive");
endmodule // dmct_timer_sva

`default_nettype wire

// ===== dmct_timer_tb_top.sv
// self-checking bench for the dual-mode compare timer
`timescale 1ns/1ns
`default_nettype none
`include "dmct_cfg.svh"

module dmct_timer_tb_top
  import dmct_pkg::*;
();
  logic                    mclk;
  logic                    rst_b;
  logic                    watchClkPin;
  dmct_power_t             powerState;
  logic [`DMCT_ADDR_W-1:0] regAddr;
  logic [7:0]              regWdata;
  logic [7:0]              regRdata;
  logic                    regWr;
  logic                    regRd;
  logic                    upperTogglePin;
  logic                    lowerTogglePin;
  logic                    upperIrq;
  logic                    lowerIrq;
  logic [7:0]              v;
  int                      nFail;
  int                      checksDone;

  // system clock 50 MHz and a slower unrelated watch clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial
  begin
    watchClkPin = 1'b0;
    forever #170 watchClkPin = ~watchClkPin;
  end

  dmct_cpu_model u_cpu (.mclk(mclk), .regRdata(regRdata), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd));

  dmct_timer u_dut (.mclk(mclk), .rst_b(rst_b), .watchClkPin(watchClkPin),
    .powerState(powerState), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .upperTogglePin(upperTogglePin),
    .lowerTogglePin(lowerTogglePin), .upperIrq(upperIrq), .lowerIrq(lowerIrq));

  // compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      nFail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic finishTest();
    $display("checks=%0d fails=%0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // power state change on a clock edge
  task automatic go(input dmct_power_t s);
    @(posedge mclk);
    powerState <= s;
  endtask

  // load registers in subactive, where only a watch-derived source keeps counting
  task automatic setup(input logic [7:0] ctl, input logic [15:0] cnt,
                       input logic [15:0] cmp, input logic [7:0] flg, input logic [7:0] alw);
    go(DMCT_PS_SUBACTIVE);
    u_cpu.wr(`DMCT_OFS_CTRL, ctl);
    u_cpu.wr(`DMCT_OFS_CNT_HI, cnt[15:8]);
    u_cpu.wr(`DMCT_OFS_CNT_LO, cnt[7:0]);
    u_cpu.wr(`DMCT_OFS_CMP_HI, cmp[15:8]);
    u_cpu.wr(`DMCT_OFS_CMP_LO, cmp[7:0]);
    u_cpu.clr_flags(8'h00);
    u_cpu.wr(`DMCT_OFS_FLAGS, flg);
    u_cpu.wr(`DMCT_OFS_IRQ_REQ, 8'h00);
    u_cpu.wr(`DMCT_OFS_IRQ_ALLOW, alw);
  endtask

  // watchdog
  initial
  begin
    repeat (20000) @(posedge mclk);
    nFail++;
    finishTest();
  end

  // test sequence
  initial
  begin
    nFail = 0;
    checksDone = 0;
    rst_b = 1'b0;
    powerState = DMCT_PS_SUBACTIVE;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    for (int a = 0; a < 8; a++)
    begin
      u_cpu.rd(a[2:0], v);
      check(v, (a == 4 || a == 5) ? `DMCT_RST_CMP : `DMCT_RST_REG);
    end
    $display("reset test finished");
    // 16-bit match at 0003 with clear; lower pin left unchecked
    setup(8'h04, 16'h0000, 16'h0003, 8'h10, 8'h02);
    go(DMCT_PS_ACTIVE);
    for (int i = 0; i < 100 && upperTogglePin !== 1'b1; i++)
      @(posedge mclk);
    check({7'h0, upperTogglePin}, 8'h01);
    check({7'h0, upperIrq}, 8'h01);
    go(DMCT_PS_STANDBY);
    u_cpu.rd(`DMCT_OFS_FLAGS, v);
    check(v, 8'h54);
    u_cpu.rd(`DMCT_OFS_CNT_HI, v);
    check(v, 8'h00);
    u_cpu.rd(`DMCT_OFS_CNT_LO, v);
    check({7'h0, v <= 8'h03}, 8'h01);
    // zero write without a prior read leaves the flags
    go(DMCT_PS_SUBACTIVE);
    u_cpu.wr(`DMCT_OFS_FLAGS, 8'h54);
    u_cpu.wr(`DMCT_OFS_FLAGS, 8'h10);
    u_cpu.rd(`DMCT_OFS_FLAGS, v);
    check(v, 8'h54);
    u_cpu.wr(`DMCT_OFS_FLAGS, 8'h10);
    u_cpu.rd(`DMCT_OFS_FLAGS, v);
    check(v, 8'h10);
    u_cpu.wr(`DMCT_OFS_CTRL, 8'h00);
    check({6'h0, upperTogglePin, lowerTogglePin}, 8'h00);
    u_cpu.wr(`DMCT_OFS_CTRL, 8'h11);
    check({6'h0, upperTogglePin, lowerTogglePin}, 8'h03);
    $display("match test finished");
    // 16-bit wrap from FFFC sets both wrap flags
    setup(8'h04, 16'hFFFC, 16'h1234, 8'h22, 8'h03);
    go(DMCT_PS_ACTIVE);
    for (int i = 0; i < 100 && upperIrq !== 1'b1; i++)
      @(posedge mclk);
    go(DMCT_PS_SUBACTIVE);
    check({6'h0, upperIrq, lowerIrq}, 8'h03);
    u_cpu.rd(`DMCT_OFS_FLAGS, v);
    check(v, 8'hAA);
    u_cpu.rd(`DMCT_OFS_CNT_HI, v);
    check(v, 8'h00);
    $display("wrap test finished");
    // two 8-bit counters, each with its own match and pin
    setup(8'hC2, 16'h0000, 16'h0201, 8'h00, 8'h00);
    go(DMCT_PS_ACTIVE);
    for (int i = 0; i < 200 && {upperTogglePin, lowerTogglePin} !== 2'h3; i++)
      @(posedge mclk);
    go(DMCT_PS_SUBACTIVE);
    check({6'h0, upperTogglePin, lowerTogglePin}, 8'h03);
    u_cpu.rd(`DMCT_OFS_FLAGS, v);
    check(v, 8'h44);
    $display("split test finished");
    // watch source: exact access in subactive, refused write in active
    setup(8'h06, 16'h0010, 16'hFFFF, 8'h00, 8'h00);
    u_cpu.wr(`DMCT_OFS_CNT_LO, 8'h33);
    u_cpu.rd(`DMCT_OFS_CNT_LO, v);
    check({7'h0, v == 8'h33 || v == 8'h34}, 8'h01);
    go(DMCT_PS_ACTIVE);
    u_cpu.wr(`DMCT_OFS_CNT_LO, 8'h55);
    u_cpu.rd(`DMCT_OFS_CNT_LO, v);
    check({7'h0, v < 8'h55}, 8'h01);
    // system-rate source stands still in subactive
    setup(8'h04, 16'h0020, 16'hFFFF, 8'h00, 8'h00);
    repeat (100) @(posedge mclk);
    u_cpu.rd(`DMCT_OFS_CNT_LO, v);
    check(v, 8'h20);
    $display("source test finished");
    finishTest();
  end
endmodule // dmct_timer_tb_top

bind dmct_timer dmct_timer_sva u_sva (.mclk(mclk), .rst_b(rst_b), .watchClkPin(watchClkPin),
  .powerState(powerState), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .upperTogglePin(upperTogglePin),
  .lowerTogglePin(lowerTogglePin), .upperIrq(upperIrq), .lowerIrq(lowerIrq));

`default_nettype wire
